/* arc_params.svh */
// Purpose: Offsets, field positions, codes and timing counts of the retry transmit control block
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ARC_OFS_STATUS      6'h01
`define ARC_OFS_COMMAND     6'h02
`define ARC_OFS_CTRL_ONE    6'h04
`define ARC_OFS_CC_MODE     6'h08
`define ARC_OFS_THRES       6'h09
`define ARC_OFS_PHY_MODE    6'h0C
`define ARC_OFS_IRQ_MASK    6'h0E
`define ARC_OFS_IRQ_STAT    6'h0F
`define ARC_OFS_AACK_CTRL   6'h17
`define ARC_OFS_RETRY_CTRL  6'h2C
`define ARC_OFS_SEED_LOW    6'h2D
`define ARC_OFS_SEED_HIGH   6'h2E
`define ARC_OFS_BE_CTRL     6'h2F

// ****************************************
// Reset values
// ****************************************
`define ARC_RST_CTRL_ONE    8'h20
`define ARC_RST_ZERO        8'h00

// ****************************************
// Radio state codes
// ****************************************
`define ARC_ST_POWER_ON     5'h00
`define ARC_ST_BUSY_RX      5'h01
`define ARC_ST_BUSY_TX      5'h02
`define ARC_ST_RX_ON        5'h06
`define ARC_ST_TRX_OFF      5'h08
`define ARC_ST_PLL_ON       5'h09
`define ARC_ST_SLEEP        5'h0F
`define ARC_ST_BUSY_AACK    5'h11
`define ARC_ST_BUSY_RETRY   5'h12
`define ARC_ST_AACK_LISTEN  5'h16
`define ARC_ST_RETRY_READY  5'h19
`define ARC_ST_LISTEN_NOCLK 5'h1C
`define ARC_ST_AACK_NOCLK   5'h1D
`define ARC_ST_BUSY_NOCLK   5'h1E
`define ARC_ST_TRANSITION   5'h1F

// ****************************************
// State commands
// ****************************************
`define ARC_CMD_NOP         5'h00
`define ARC_CMD_TX_START    5'h02
`define ARC_CMD_FORCE_OFF   5'h03
`define ARC_CMD_FORCE_PLL   5'h04

// ****************************************
// Transaction result codes
// ****************************************
`define ARC_RES_SUCCESS     3'h0
`define ARC_RES_PENDING     3'h1
`define ARC_RES_WAIT_ACK    3'h2
`define ARC_RES_CHAN_FAIL   3'h3
`define ARC_RES_NO_ACK      3'h5
`define ARC_RES_INVALID     3'h7

// ****************************************
// Field positions
// ****************************************
`define ARC_IRQ_RX_START    2
`define ARC_IRQ_TRANSACTION_END     3
`define ARC_IRQ_CHANNEL_CHECK_DONE    4
`define ARC_IRQ_ADDR_MATCH  5
`define ARC_NO_CSMA         3'h7

// ****************************************
// Timing, in symbols, nanoseconds and clock cycles
// ****************************************
`define ARC_UNIT_BACKOFF    20
`define ARC_TURNAROUND      12
`define ARC_SHR_BPSK        40
`define ARC_SPO_BPSK        8
`define ARC_SHR_OQPSK       10
`define ARC_SPO_OQPSK       2
`define ARC_ACK_OCTETS      6
`define ARC_CCA_SYMS        8
`define ARC_CLK_NS          100
`define ARC_SYM_NS_BPSK     50000
`define ARC_SYM_NS_OQPSK    40000
`define ARC_TRANS_CYC       4

`endif

/* arc_pkg.sv */
// Purpose: Types of the retry transmit control block
// Assumes: Nothing
// Notes:   Constants live in arc_params.svh
package arc_pkg;

	// Retry transaction sequencer
	typedef enum logic [2:0] {
		ARC_IDLE,
		ARC_BACKOFF,
		ARC_CCA,
		ARC_TX,
		ARC_ACKWAIT,
		ARC_ACKRX
	} arc_fsm_t;

	// Whole state of the control block
	typedef struct packed {
		arc_fsm_t    fsm;
		logic [4:0]  radio_state_code;
		logic [4:0]  target;
		logic [2:0]  trans_cnt;
		logic [2:0]  transaction_result;
		logic [4:0]  state_command_field;
		logic        channel_check_done;
		logic        channel_idle_flag;
		logic [7:0]  ctrl_one;
		logic [7:0]  cc_mode;
		logic [7:0]  thres;
		logic        phy_oqpsk;
		logic [7:0]  irq_mask;
		logic [7:0]  irq_stat;
		logic [7:0]  aack_ctrl;
		logic [7:0]  retry_ctrl;
		logic [7:0]  seed_low;
		logic [7:0]  seed_high;
		logic [7:0]  be_ctrl;
		logic [12:0] sym_cnt;
		logic [2:0]  csma_cnt;
		logic [3:0]  frame_cnt;
		logic [3:0]  be;
		logic [7:0]  lfsr;
		logic        addr_seen;
		logic        tx_start;
		logic        rx_enable;
		logic [7:0]  rdata;
		logic [1:0]  sleep_sync;
		logic        sleep_prev;
	} arc_state_t;

endpackage

/* arc_sym_strobe.sv */
// Purpose: Symbol-rate strobe from the device clock
// Assumes: One clock, synchronous active-low reset
// Notes:   Count restarts while run is low
`timescale 1ns/1ns

`include "arc_params.svh"

module arc_sym_strobe #(
	parameter int BPSK_CYC  = `ARC_SYM_NS_BPSK / `ARC_CLK_NS,
	parameter int OQPSK_CYC = `ARC_SYM_NS_OQPSK / `ARC_CLK_NS
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic oqpsk,
	input  wire logic run,
	output logic      sym_stb
);

	logic [12:0] cnt;
	logic [12:0] next_cnt;
	logic [12:0] last;

	// Period of one header symbol in the chosen mode
	always_comb begin
		last     = oqpsk ? 13'(OQPSK_CYC - 1) : 13'(BPSK_CYC - 1);
		sym_stb  = run && (cnt == last);
		next_cnt = (!run || sym_stb) ? 13'h0000 : cnt + 13'h0001;
	end

	// Cycle counter
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt <= 13'h0000;
		end else begin
			cnt <= next_cnt;
		end
	end

endmodule

/* arc_retry_ctrl.sv */
// Purpose: Transaction control and status for transmit with automatic retry
// Assumes: Radio datapath on the same clock; sleep pin asynchronous
// Notes:   Register port is a plain strobed access, one register per address
`timescale 1ns/1ns
`include "arc_params.svh"
module arc_retry_ctrl #(
	parameter int BPSK_CYC  = `ARC_SYM_NS_BPSK / `ARC_CLK_NS,
	parameter int OQPSK_CYC = `ARC_SYM_NS_OQPSK / `ARC_CLK_NS
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [5:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_we,
	input  wire logic       reg_re,
	output logic      [7:0] reg_rdata,
	output logic            irq,
	input  wire logic       sleep_trigger_pin,
	output logic            radio_tx_start,
	output logic            radio_rx_enable,
	input  wire logic       radio_tx_done,
	input  wire logic       radio_ack_req,
	input  wire logic       radio_cca_idle,
	input  wire logic       radio_phr_done,
	input  wire logic [6:0] radio_phr_len,
	input  wire logic       radio_addr_match,
	input  wire logic       radio_frame_end,
	input  wire logic       radio_fcs_ok,
	input  wire logic       radio_ack_ok,
	input  wire logic       radio_ack_pending
);
	arc_pkg::arc_state_t s;
	arc_pkg::arc_state_t next_s;
	logic                sym_stb, sym_run;
	// ****************************************
	// Helpers
	// ****************************************
	// Acknowledgment wait in header symbols
	function automatic logic [12:0] ack_wait(input logic oqpsk);
		int shr, spo;
		shr = oqpsk ? `ARC_SHR_OQPSK : `ARC_SHR_BPSK;
		spo = oqpsk ? `ARC_SPO_OQPSK : `ARC_SPO_BPSK;
		return 13'(`ARC_UNIT_BACKOFF + `ARC_TURNAROUND + shr + `ARC_ACK_OCTETS * spo);
	endfunction
	// Random backoff length in symbols
	function automatic logic [12:0] backoff_len(input logic [3:0] be, input logic [7:0] rnd);
		logic [7:0] msk;
		msk = (be >= 4'h8) ? 8'hFF : 8'((9'h001 << be) - 9'h001);
		return 13'(rnd & msk) * 13'(`ARC_UNIT_BACKOFF);
	endfunction
	// Target state of a command, transition code when none
	function automatic logic [4:0] cmd_target(input logic [4:0] cmd);
		case (cmd)
			`ARC_CMD_FORCE_OFF, `ARC_ST_TRX_OFF: cmd_target = `ARC_ST_TRX_OFF;
			`ARC_CMD_FORCE_PLL, `ARC_ST_PLL_ON:  cmd_target = `ARC_ST_PLL_ON;
			`ARC_ST_RX_ON:                       cmd_target = `ARC_ST_RX_ON;
			`ARC_ST_AACK_LISTEN:                 cmd_target = `ARC_ST_AACK_LISTEN;
			`ARC_ST_RETRY_READY:                 cmd_target = `ARC_ST_RETRY_READY;
			default:                             cmd_target = `ARC_ST_TRANSITION;
		endcase
	endfunction
	// ****************************************
	// Symbol strobe
	// ****************************************
	// Strobe runs only while a symbol count is open
	assign sym_run = (s.fsm != arc_pkg::ARC_IDLE) && (s.fsm != arc_pkg::ARC_TX);
	arc_sym_strobe #(
		.BPSK_CYC  (BPSK_CYC),
		.OQPSK_CYC (OQPSK_CYC)
	) u_sym (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.oqpsk   (s.phy_oqpsk),
		.run     (sym_run),
		.sym_stb (sym_stb)
	);
	// ****************************************
	// Next state
	// ****************************************
	// Registers, radio states and retry sequencer
	always_comb begin
		logic [7:0] ev, clr;
		logic       asleep, pin_rise, pin_fall, start_retry, extended;
		logic [4:0] tgt;
		ev          = 8'h00;
		clr         = 8'h00;
		next_s      = s;
		next_s.tx_start   = 1'b0;
		next_s.sleep_sync = {s.sleep_sync[0], sleep_trigger_pin};
		next_s.sleep_prev = s.sleep_sync[1];
		next_s.lfsr       = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
		asleep      = (s.radio_state_code == `ARC_ST_SLEEP);
		pin_rise    = s.sleep_sync[1] && !s.sleep_prev;
		pin_fall    = !s.sleep_sync[1] && s.sleep_prev;
		start_retry = 1'b0;
		extended    = (s.radio_state_code[4] == 1'b1);
		tgt         = cmd_target(reg_wdata[4:0]);
		// Register reads, none in sleep
		if (reg_re && !asleep) begin
			case (reg_addr)
				`ARC_OFS_STATUS:     next_s.rdata = {s.channel_check_done, s.channel_idle_flag, 1'b0,
					s.radio_state_code};
				`ARC_OFS_COMMAND:    next_s.rdata = {s.transaction_result, s.state_command_field};
				`ARC_OFS_CTRL_ONE:   next_s.rdata = s.ctrl_one;
				`ARC_OFS_CC_MODE:    next_s.rdata = s.cc_mode;
				`ARC_OFS_THRES:      next_s.rdata = s.thres;
				`ARC_OFS_PHY_MODE:   next_s.rdata = {7'h00, s.phy_oqpsk};
				`ARC_OFS_IRQ_MASK:   next_s.rdata = s.irq_mask;
				`ARC_OFS_IRQ_STAT:   next_s.rdata = s.irq_stat;
				`ARC_OFS_AACK_CTRL:  next_s.rdata = s.aack_ctrl;
				`ARC_OFS_RETRY_CTRL: next_s.rdata = s.retry_ctrl;
				`ARC_OFS_SEED_LOW:   next_s.rdata = s.seed_low;
				`ARC_OFS_SEED_HIGH:  next_s.rdata = s.seed_high;
				`ARC_OFS_BE_CTRL:    next_s.rdata = s.be_ctrl;
				default:             next_s.rdata = 8'h00;
			endcase
			clr = (reg_addr == `ARC_OFS_IRQ_STAT) ? s.irq_stat : 8'h00;
		end
		// Register writes, none in sleep; status register has no write path
		if (reg_we && !asleep) begin
			case (reg_addr)
				`ARC_OFS_CTRL_ONE:   next_s.ctrl_one = reg_wdata;
				`ARC_OFS_CC_MODE:    next_s.cc_mode = reg_wdata;
				`ARC_OFS_THRES:      next_s.thres = reg_wdata;
				`ARC_OFS_PHY_MODE:   next_s.phy_oqpsk = reg_wdata[0];
				`ARC_OFS_IRQ_MASK:   next_s.irq_mask = reg_wdata;
				`ARC_OFS_AACK_CTRL:  next_s.aack_ctrl = reg_wdata;
				`ARC_OFS_RETRY_CTRL: next_s.retry_ctrl = reg_wdata;
				`ARC_OFS_SEED_LOW: begin
					next_s.seed_low = reg_wdata;
					next_s.lfsr     = (reg_wdata == 8'h00) ? 8'h01 : reg_wdata;
				end
				`ARC_OFS_SEED_HIGH:  next_s.seed_high = reg_wdata;
				`ARC_OFS_BE_CTRL:    next_s.be_ctrl = reg_wdata;
				`ARC_OFS_COMMAND: begin
					next_s.state_command_field = reg_wdata[4:0];
					// Transmit start in the ready states
					if (reg_wdata[4:0] == `ARC_CMD_TX_START) begin
						if (s.radio_state_code == `ARC_ST_RETRY_READY && s.fsm == arc_pkg::ARC_IDLE) begin
							start_retry = 1'b1;
						end else if (s.radio_state_code == `ARC_ST_PLL_ON) begin
							next_s.radio_state_code = `ARC_ST_BUSY_TX;
							next_s.tx_start         = 1'b1;
						end
					// Other listed codes start a transition, the rest do nothing
					end else if (tgt != `ARC_ST_TRANSITION) begin
						next_s.target           = tgt;
						next_s.trans_cnt        = 3'(`ARC_TRANS_CYC);
						next_s.radio_state_code = `ARC_ST_TRANSITION;
						next_s.fsm              = arc_pkg::ARC_IDLE;
						next_s.rx_enable        = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// Transition countdown
		if (s.radio_state_code == `ARC_ST_TRANSITION) begin
			if (s.trans_cnt == 3'h0) begin
				next_s.radio_state_code = s.target;
				next_s.rx_enable        = (s.target == `ARC_ST_RX_ON) || (s.target == `ARC_ST_AACK_LISTEN);
			end else begin
				next_s.trans_cnt = s.trans_cnt - 3'h1;
			end
		end
		// Sleep pin: off state sleeps, retry ready starts a frame
		if (pin_rise && s.radio_state_code == `ARC_ST_TRX_OFF) begin
			next_s.radio_state_code = `ARC_ST_SLEEP;
		end else if (pin_fall && asleep) begin
			next_s.radio_state_code = `ARC_ST_TRX_OFF;
		end else if (pin_rise && s.radio_state_code == `ARC_ST_RETRY_READY && s.fsm == arc_pkg::ARC_IDLE) begin
			start_retry = 1'b1;
		end
		// Basic receive and transmit
		if (s.radio_state_code == `ARC_ST_BUSY_TX && radio_tx_done) begin
			next_s.radio_state_code = `ARC_ST_PLL_ON;
			ev[`ARC_IRQ_TRANSACTION_END]    = 1'b1;
		end
		if (s.radio_state_code == `ARC_ST_RX_ON && radio_phr_done && radio_phr_len != 7'h00) begin
			next_s.radio_state_code  = `ARC_ST_BUSY_RX;
			ev[`ARC_IRQ_RX_START]    = 1'b1;
		end
		if (s.radio_state_code == `ARC_ST_BUSY_RX && radio_addr_match) begin
			ev[`ARC_IRQ_ADDR_MATCH] = 1'b1;
		end
		if (s.radio_state_code == `ARC_ST_BUSY_RX && radio_frame_end) begin
			next_s.radio_state_code = `ARC_ST_RX_ON;
			ev[`ARC_IRQ_TRANSACTION_END]    = 1'b1;
		end
		// Auto-ack receive
		if (s.radio_state_code == `ARC_ST_AACK_LISTEN && radio_phr_done && radio_phr_len != 7'h00) begin
			next_s.radio_state_code   = `ARC_ST_BUSY_AACK;
			next_s.transaction_result = `ARC_RES_INVALID;
			next_s.addr_seen          = 1'b0;
			ev[`ARC_IRQ_RX_START]     = 1'b1;
		end
		if (s.radio_state_code == `ARC_ST_BUSY_AACK && radio_addr_match) begin
			next_s.addr_seen        = 1'b1;
			ev[`ARC_IRQ_ADDR_MATCH] = 1'b1;
		end
		if (s.radio_state_code == `ARC_ST_BUSY_AACK && radio_frame_end) begin
			next_s.radio_state_code = `ARC_ST_AACK_LISTEN;
			if ((s.addr_seen || radio_addr_match) && radio_fcs_ok) begin
				next_s.transaction_result = `ARC_RES_SUCCESS;
				ev[`ARC_IRQ_TRANSACTION_END]      = 1'b1;
			end
		end
		// Retry transaction start
		if (start_retry) begin
			next_s.radio_state_code   = `ARC_ST_BUSY_RETRY;
			next_s.transaction_result = `ARC_RES_INVALID;
			next_s.csma_cnt           = 3'h0;
			next_s.frame_cnt          = 4'h0;
			next_s.be                 = s.be_ctrl[3:0];
			if (s.retry_ctrl[3:1] == `ARC_NO_CSMA) begin
				next_s.fsm      = arc_pkg::ARC_TX;
				next_s.tx_start = 1'b1;
			end else begin
				next_s.fsm     = arc_pkg::ARC_BACKOFF;
				next_s.sym_cnt = backoff_len(s.be_ctrl[3:0], s.lfsr);
			end
		end
		// Retry sequencer, counts on header symbols
		case (s.fsm)
			arc_pkg::ARC_IDLE: ;
			arc_pkg::ARC_BACKOFF: begin
				if (s.sym_cnt == 13'h0000) begin
					next_s.fsm     = arc_pkg::ARC_CCA;
					next_s.sym_cnt = 13'(`ARC_CCA_SYMS);
				end else if (sym_stb) begin
					next_s.sym_cnt = s.sym_cnt - 13'h0001;
				end
			end
			arc_pkg::ARC_CCA: begin
				// Check ends with no check-done interrupt or status bits; a last failure raises transaction end
				if (sym_stb && s.sym_cnt == 13'h0001) begin
					if (radio_cca_idle) begin
						next_s.fsm      = arc_pkg::ARC_TX;
						next_s.tx_start = 1'b1;
					end else if (s.csma_cnt == s.retry_ctrl[3:1]) begin
						next_s.fsm                = arc_pkg::ARC_IDLE;
						next_s.transaction_result = `ARC_RES_CHAN_FAIL;
						next_s.radio_state_code   = `ARC_ST_RETRY_READY;
						ev[`ARC_IRQ_TRANSACTION_END]      = 1'b1;
					end else begin
						next_s.csma_cnt = s.csma_cnt + 3'h1;
						next_s.be       = (s.be < s.be_ctrl[7:4]) ? s.be + 4'h1 : s.be_ctrl[7:4];
						next_s.fsm      = arc_pkg::ARC_BACKOFF;
						next_s.sym_cnt  = backoff_len(s.be, s.lfsr);
					end
				end else if (sym_stb) begin
					next_s.sym_cnt = s.sym_cnt - 13'h0001;
				end
			end
			arc_pkg::ARC_TX: begin
				if (radio_tx_done) begin
					if (radio_ack_req) begin
						next_s.fsm                = arc_pkg::ARC_ACKWAIT;
						next_s.transaction_result = `ARC_RES_WAIT_ACK;
						next_s.rx_enable          = 1'b1;
						next_s.sym_cnt            = ack_wait(s.phy_oqpsk);
					end else begin
						next_s.fsm                = arc_pkg::ARC_IDLE;
						next_s.transaction_result = `ARC_RES_SUCCESS;
						next_s.radio_state_code   = `ARC_ST_RETRY_READY;
						ev[`ARC_IRQ_TRANSACTION_END]      = 1'b1;
					end
				end
			end
			arc_pkg::ARC_ACKWAIT: begin
				// Ack start is expected inside the wait window
				if (radio_phr_done) begin
					next_s.fsm = arc_pkg::ARC_ACKRX;
				end else if (sym_stb && s.sym_cnt == 13'h0001) begin
					next_s.rx_enable = 1'b0;
					if (s.frame_cnt == s.retry_ctrl[7:4] || s.retry_ctrl[3:1] == `ARC_NO_CSMA) begin
						next_s.fsm                = arc_pkg::ARC_IDLE;
						next_s.transaction_result = `ARC_RES_NO_ACK;
						next_s.radio_state_code   = `ARC_ST_RETRY_READY;
						ev[`ARC_IRQ_TRANSACTION_END]      = 1'b1;
					end else begin
						next_s.frame_cnt = s.frame_cnt + 4'h1;
						next_s.csma_cnt  = 3'h0;
						next_s.be        = s.be_ctrl[3:0];
						next_s.fsm       = arc_pkg::ARC_BACKOFF;
						next_s.sym_cnt   = backoff_len(s.be_ctrl[3:0], s.lfsr);
					end
				end else if (sym_stb) begin
					next_s.sym_cnt = s.sym_cnt - 13'h0001;
				end
			end
			arc_pkg::ARC_ACKRX: begin
				// Receive-start and match are held back here
				if (radio_frame_end) begin
					if (radio_fcs_ok && radio_ack_ok) begin
						next_s.fsm                = arc_pkg::ARC_IDLE;
						next_s.rx_enable          = 1'b0;
						next_s.radio_state_code   = `ARC_ST_RETRY_READY;
						next_s.transaction_result = radio_ack_pending ? `ARC_RES_PENDING : `ARC_RES_SUCCESS;
						ev[`ARC_IRQ_TRANSACTION_END]      = 1'b1;
					end else begin
						next_s.fsm = arc_pkg::ARC_ACKWAIT;
					end
				end
			end
			default: next_s.fsm = arc_pkg::ARC_IDLE;
		endcase
		// Channel check bits hold in extended modes; nothing else sets them
		if (extended) begin
			next_s.channel_check_done = s.channel_check_done;
			next_s.channel_idle_flag  = s.channel_idle_flag;
		end
		// Sticky status, a new event beats a read clear
		next_s.irq_stat = (s.irq_stat & ~clr) | ev;
	end
	// ****************************************
	// State register
	// ****************************************
	// Whole state, synchronous reset
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s                      <= '0;
			s.fsm                  <= arc_pkg::ARC_IDLE;
			s.radio_state_code     <= `ARC_ST_TRX_OFF;
			s.ctrl_one             <= `ARC_RST_CTRL_ONE;
			s.transaction_result   <= 3'h0;
			s.lfsr                 <= 8'h01;
		end else begin
			s <= next_s;
		end
	end
	// ****************************************
	// Outputs
	// ****************************************
	// Registered outputs, interrupt from flops
	assign reg_rdata       = s.rdata;
	assign irq             = |(s.irq_stat & s.irq_mask);
	assign radio_tx_start  = s.tx_start;
	assign radio_rx_enable = s.rx_enable;
endmodule

/* arc_retry_ctrl_asserts.sv */
// Purpose: Port checks of the retry control block
// Assumes: One clock, sync active-low reset
// Notes: Bound to arc_retry_ctrl
`timescale 1ns/1ns
module arc_retry_ctrl_asserts #(
	parameter int BPSK_CYC  = 500,
	parameter int OQPSK_CYC = 400
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_we,
	input wire logic       reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq,
	input wire logic       radio_tx_start,
	input wire logic       radio_rx_enable,
	input wire logic       radio_tx_done,
	input wire logic       radio_ack_req,
	input wire logic       radio_frame_end,
	input wire logic       radio_fcs_ok,
	input wire logic       radio_ack_ok
);
	localparam int ACK_MAX = 120 * BPSK_CYC + 16;
	logic        retry_on;
	logic [7:0]  mask_q;
	logic [15:0] wait_cnt;
	// Track retry mode, mask and ack wait length
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			retry_on <= 1'b0;
			mask_q <= 8'h00;
			wait_cnt <= 16'h0000;
		end else begin
			if (reg_we && reg_addr == 6'h0E) begin
				mask_q <= reg_wdata;
			end
			if (reg_we && reg_addr == 6'h02 && reg_wdata[4:0] != 5'h02 && reg_wdata[4:0] != 5'h00) begin
				retry_on <= (reg_wdata[4:0] == 5'h19);
			end
			wait_cnt <= (retry_on && radio_rx_enable) ? wait_cnt + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_reset_quiet: assert property (@(posedge ref_clk) disable iff (1'b0)
		!rst_n |=> !irq && reg_rdata == 8'h00 && !radio_tx_start && !radio_rx_enable)
		else $error("outputs not cleared by reset");
	a_tx_one_pulse: assert property (radio_tx_start |=> !radio_tx_start)
		else $error("transmit start longer than one cycle");
	a_rdata_holds: assert property (!reg_re |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	a_irq_masked: assert property (mask_q == 8'h00 |-> !irq)
		else $error("interrupt with all sources masked");
	a_rx_for_ack: assert property (retry_on && radio_tx_done && radio_ack_req |=> radio_rx_enable)
		else $error("receiver not opened for ack");
	a_ack_closes: assert property (retry_on && radio_rx_enable && radio_frame_end && radio_ack_ok
		&& radio_fcs_ok |=> !radio_rx_enable) else $error("receiver left on after ack");
	a_end_irq: assert property (retry_on && radio_rx_enable && radio_frame_end && radio_ack_ok
		&& radio_fcs_ok && mask_q[3] |=> irq) else $error("no end interrupt after ack");
	a_ack_bound: assert property (wait_cnt <= ACK_MAX)
		else $error("ack wait too long");
	c_ack: cover property (retry_on && radio_frame_end && radio_ack_ok);
	c_irq: cover property ($rose(irq));
	c_no_ack: cover property (retry_on && wait_cnt > 16'h0190);
endmodule
bind arc_retry_ctrl arc_retry_ctrl_asserts #(.BPSK_CYC(BPSK_CYC), .OQPSK_CYC(OQPSK_CYC)) i_chk (.*);

/* arc_far_node.sv */
// Purpose: Radio and remote node answering frames
// Assumes: Same clock as the control block
// Notes: ack_en low models a silent node
`timescale 1ns/1ns
module arc_far_node (
	input  wire logic       ref_clk,
	input  wire logic       radio_tx_start,
	input  wire logic       ack_en,
	input  wire logic       pend,
	output logic            radio_tx_done,
	output logic            radio_ack_req,
	output logic            radio_phr_done,
	output logic      [6:0] radio_phr_len,
	output logic            radio_addr_match,
	output logic            radio_frame_end,
	output logic            radio_fcs_ok,
	output logic            radio_ack_ok,
	output logic            radio_ack_pending
);
	// Send frame, then answer within turnaround plus backoff
	initial begin
		{radio_tx_done, radio_ack_req, radio_phr_done, radio_addr_match} = 4'h0;
		{radio_frame_end, radio_fcs_ok, radio_ack_ok, radio_ack_pending} = 4'h0;
		radio_phr_len = 7'h00;
		forever begin
			@(posedge ref_clk);
			if (radio_tx_start) begin
				repeat (20) @(posedge ref_clk);
				{radio_tx_done, radio_ack_req} <= 2'h3;
				@(posedge ref_clk);
				{radio_tx_done, radio_ack_req} <= 2'h0;
				if (ack_en) begin
					repeat (24) @(posedge ref_clk);
					{radio_phr_done, radio_addr_match, radio_phr_len} <= {2'h3, 7'h05};
					@(posedge ref_clk);
					{radio_phr_done, radio_addr_match, radio_phr_len} <= {2'h0, 7'h7A};
					repeat (10) @(posedge ref_clk);
					{radio_frame_end, radio_fcs_ok, radio_ack_ok, radio_ack_pending} <= {3'h7, pend};
					@(posedge ref_clk);
					{radio_frame_end, radio_fcs_ok, radio_ack_ok, radio_ack_pending} <= {3'h0, ~pend};
				end
			end
		end
	end
endmodule

/* tb_arc_retry_ctrl.sv */
// Purpose: Self-checking bench of the retry control block
// Assumes: Short symbol counts for run time
// Notes: Register port driven by rd and wr tasks
`timescale 1ns/1ns
module tb_arc_retry_ctrl;
	localparam int OC = 8;
	localparam int BC = 10;
	logic ref_clk = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0, sleep_trigger_pin = 1'b0;
	logic radio_cca_idle = 1'b1, ack_en = 1'b1, pend = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [6:0] radio_phr_len;
	logic irq, radio_tx_start, radio_rx_enable, radio_tx_done, radio_ack_req, radio_phr_done;
	logic radio_addr_match, radio_frame_end, radio_fcs_ok, radio_ack_ok, radio_ack_pending;
	int err_total = 0, n_checks = 0, rx_cyc = 0;
	arc_retry_ctrl #(.BPSK_CYC(BC), .OQPSK_CYC(OC)) i_dut (.*);
	arc_far_node i_far (.*);
	// Clock and receiver-on count
	initial forever #50 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (radio_rx_enable) rx_cyc++;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		{reg_addr, reg_wdata, reg_we} <= {a, d, 1'b1};
		@(posedge ref_clk);
		reg_we <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		{reg_addr, reg_re} <= {a, 1'b1};
		@(posedge ref_clk);
		reg_re <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
	endtask
	// One retry transaction with its final result
	task automatic run(input logic [7:0] res);
		int n;
		rx_cyc = 0;
		wr(6'h02, 8'h02);
		rd(6'h01, 8'h12);
		rd(6'h02, 8'hE2);
		for (n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge ref_clk);
		chk("irq", 16'h0001, {15'h0000, irq});
		if (n >= 5000) close_out;
		rd(6'h01, 8'h19);
		rd(6'h02, {res[2:0], 5'h02});
		rd(6'h0F, 8'h08);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		$display("test end result %h", res);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(6'h01, 8'h08);
		rd(6'h02, 8'h00);
		rd(6'h04, 8'h20);
		rd(6'h2F, 8'h00);
		rd(6'h3F, 8'h00);
		wr(6'h01, 8'hFF);
		rd(6'h01, 8'h08);
		$display("test end reset values");
		wr(6'h0E, 8'h2C);
		wr(6'h02, 8'h19);
		repeat (8) @(posedge ref_clk);
		rd(6'h01, 8'h19);
		for (int i = 0; i < 2; i++) begin
			wr(6'h0C, 8'(i));
			pend = i[0];
			run(8'(i));
		end
		ack_en = 1'b0;
		run(8'h05);
		chk("ack wait", 16'h0001, 16'(rx_cyc >= 53 * OC && rx_cyc <= 55 * OC));
		wr(6'h0C, 8'h00);
		run(8'h05);
		chk("ack wait bpsk", 16'h0001, 16'(rx_cyc >= 119 * BC && rx_cyc <= 121 * BC));
		wr(6'h2C, 8'h02);
		rd(6'h2C, 8'h02);
		@(posedge ref_clk);
		radio_cca_idle <= 1'b0;
		run(8'h03);
		wr(6'h02, 8'h08);
		repeat (8) @(posedge ref_clk);
		rd(6'h01, 8'h08);
		@(posedge ref_clk);
		sleep_trigger_pin <= 1'b1;
		repeat (6) @(posedge ref_clk);
		wr(6'h0C, 8'h01);
		rd(6'h01, 8'h08);
		@(posedge ref_clk);
		sleep_trigger_pin <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rd(6'h0C, 8'h00);
		$display("test end sleep");
		close_out;
	end
endmodule
